// file: core/dre_regs.svh
// dre_regs.svh: register offsets, field positions, reset values and counts
`ifndef DRE_REGS_SVH
`define DRE_REGS_SVH
`define DRE_A_DIVMSB 13'h0017
`define DRE_A_DIV 13'h0018
`define DRE_A_DIVSRC 13'h0019
`define DRE_A_RXBG 13'h001a
`define DRE_A_XTUNE 13'h001b
`define DRE_A_XSPARE 13'h001c
`define DRE_A_REFOPT 13'h001d
`define DRE_F_PMSB 0
`define DRE_F_PDIV_HI 7
`define DRE_F_PDIV_LO 3
`define DRE_F_PRE_HI 2
`define DRE_F_PRE_LO 0
`define DRE_F_DEN 7
`define DRE_F_RXRST 7
`define DRE_F_BG_HI 6
`define DRE_F_BG_LO 2
`define DRE_F_BGM 0
`define DRE_F_TAUTO 7
`define DRE_F_TCODE_HI 5
`define DRE_F_TCODE_LO 0
`define DRE_F_MULT 2
`define DRE_F_XF 0
`define DRE_RST_POST 6'h20
`define DRE_RST_PRE 3'h0
`define DRE_RST_DEN 1'b0
`define DRE_RST_BG 5'h00
`define DRE_RST_BGM 1'b0
`define DRE_RST_TAUTO 1'b1
`define DRE_RST_TCODE 6'h00
`define DRE_RST_MULT 1'b0
`define DRE_RST_XF 1'b0
`define DRE_PRE_OFFSET 4'h4
`define DRE_INSTR_LAST 4'hf
`define DRE_BYTE_LAST 4'h7
`endif

// file: core/dre_pkg.sv
// dre_pkg: types shared by the register bank modules
package dre_pkg;
  typedef enum logic [2:0] {
    DRE_IDLE = 3'b001,
    DRE_INSTR = 3'b010,
    DRE_DATA = 3'b100
  } dre_spi_state_t;
endpackage

// file: core/dre_cfg_if.sv
// dre_cfg_if: register fields passed from the bank to the select logic
`timescale 1ns/1ps
`default_nettype none
interface dre_cfg_if;
  logic div_en;
  logic [5:0] post_div;
  logic [2:0] pre_code;
  logic bg_manual;
  logic [4:0] bg_adj;
  logic tune_auto;
  logic [5:0] tune_code;
  logic mult_sel;
  logic crystal_input_force;
  modport regs (output div_en, post_div, pre_code, bg_manual, bg_adj, tune_auto, tune_code,
    mult_sel, crystal_input_force);
  modport sel (input div_en, post_div, pre_code, bg_manual, bg_adj, tune_auto, tune_code,
    mult_sel, crystal_input_force);
endinterface
`default_nettype wire

// file: core/dre_sync.sv
// dre_sync: two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module dre_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb
  begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule
`default_nettype wire

// file: core/dre_sel.sv
// dre_sel: applies register fields or automatic choices to the analog controls
`timescale 1ns/1ps
`default_nettype none
`include "dre_regs.svh"
module dre_sel (
  input wire logic clk,
  input wire logic rstn,
  dre_cfg_if.sel cfg,
  input wire logic ext_ref_present,
  output logic post_divider_valid,
  output logic [5:0] post_divider,
  output logic [3:0] prescale_ratio,
  output logic bandgap_manual,
  output logic [4:0] bandgap_value,
  output logic tune_auto,
  output logic [5:0] tune_cap_qpf,
  output logic mult_insert,
  output logic ref_use_crystal
);
  import dre_pkg::*;

  logic pdv_d;
  logic [5:0] post_d;
  logic [3:0] ratio_d;
  logic bgm_d;
  logic [4:0] bg_d;
  logic ta_d;
  logic [5:0] cap_d;
  logic mult_d;
  logic crystal_input_d;

  always_comb
  begin
    pdv_d = cfg.div_en;
    // zero marks "dividers come from the strap pins"
    post_d = cfg.div_en ? cfg.post_div : 6'h00;
    ratio_d = cfg.div_en ? {1'b0, cfg.pre_code} + `DRE_PRE_OFFSET : 4'h0;
    bgm_d = cfg.bg_manual;
    bg_d = cfg.bg_manual ? cfg.bg_adj : 5'h00;
    ta_d = cfg.tune_auto;
    cap_d = cfg.tune_auto ? 6'h00 : ~cfg.tune_code;
    mult_d = cfg.mult_sel;
    crystal_input_d = cfg.crystal_input_force | ~ext_ref_present;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      post_divider_valid <= 1'b0;
      post_divider <= 6'h00;
      prescale_ratio <= 4'h0;
      bandgap_manual <= 1'b0;
      bandgap_value <= 5'h00;
      tune_auto <= 1'b1;
      tune_cap_qpf <= 6'h00;
      mult_insert <= 1'b0;
      ref_use_crystal <= 1'b0;
    end
    else
    begin
      post_divider_valid <= pdv_d;
      post_divider <= post_d;
      prescale_ratio <= ratio_d;
      bandgap_manual <= bgm_d;
      bandgap_value <= bg_d;
      tune_auto <= ta_d;
      tune_cap_qpf <= cap_d;
      mult_insert <= mult_d;
      ref_use_crystal <= crystal_input_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_div_from_straps: assert property (!cfg.div_en |=> post_divider == 6'h00 &&
    prescale_ratio == 4'h0 && !post_divider_valid)
    else $error("divider fields leaked while strap source selected");
  a_prescale_map: assert property (cfg.div_en && cfg.pre_code == 3'h7 |=>
    prescale_ratio == 4'hb && post_divider == $past(cfg.post_div))
    else $error("prescale code 7 did not give ratio 11");
  a_tune_inverted: assert property (!cfg.tune_auto |=>
    (tune_cap_qpf ^ $past(cfg.tune_code)) == 6'h3f)
    else $error("tuning code not applied inverted");
  a_bandgap_apply: assert property (cfg.bg_manual |=>
    bandgap_value == $past(cfg.bg_adj) && bandgap_manual)
    else $error("bandgap adjust not applied");
  a_ref_crystal: assert property (cfg.crystal_input_force || !ext_ref_present |=> ref_use_crystal)
    else $error("crystal input not selected");
  a_mult_follow: assert property ($rose(cfg.mult_sel) |=> mult_insert)
    else $error("multiplier not inserted");
endmodule
`default_nettype wire

// file: core/dre_top.sv
// dre_top: three-wire serial control port and divider/receiver/crystal registers
`timescale 1ns/1ps
`default_nettype none
`include "dre_regs.svh"
module dre_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  input wire logic [5:0] strap_y,
  input wire logic ext_ref_present,
  output logic [5:0] div_strap_code,
  output logic post_divider_valid,
  output logic [5:0] post_divider,
  output logic [3:0] prescale_ratio,
  output logic rx_reset,
  output logic bandgap_manual,
  output logic [4:0] bandgap_value,
  output logic tune_auto,
  output logic [5:0] tune_cap_qpf,
  output logic mult_insert,
  output logic ref_use_crystal
);
  import dre_pkg::*;

  dre_cfg_if cfg ();

  logic sclk_s;
  logic csb_s;
  logic sdio_s;
  logic ext_s;
  logic [5:0] strap_s;
  logic sclk_p_q;
  logic rise;
  logic fall;

  dre_sync #(
    .W(10)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({sclk, csb_n, sdio_i, ext_ref_present, strap_y}),
    .q({sclk_s, csb_s, sdio_s, ext_s, strap_s})
  );

  // edges found on the second stage only
  assign rise = sclk_s & ~sclk_p_q;
  assign fall = ~sclk_s & sclk_p_q;

  dre_spi_state_t state_q;
  dre_spi_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [15:0] sh_q;
  logic [15:0] sh_d;
  logic rd_q;
  logic rd_d;
  logic [12:0] addr_q;
  logic [12:0] addr_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [5:0] strap_q;
  logic wr_stb;
  logic instr_done;
  logic [12:0] instr_addr;
  logic [7:0] wr_data;
  // 32 splits into msb 1 and low five bits zero
  localparam logic [5:0] rst_post = `DRE_RST_POST;

  // register fields
  logic pmsb_q;
  logic pmsb_d;
  logic [4:0] pdiv_q;
  logic [4:0] pdiv_d;
  logic [2:0] pre_q;
  logic [2:0] pre_d;
  logic den_q;
  logic den_d;
  logic rxr_q;
  logic rxr_d;
  logic [4:0] bg_q;
  logic [4:0] bg_d;
  logic bgm_q;
  logic bgm_d;
  logic tauto_q;
  logic tauto_d;
  logic [5:0] tcode_q;
  logic [5:0] tcode_d;
  logic mult_q;
  logic mult_d;
  logic xf_q;
  logic xf_d;

  function automatic logic [7:0] rd_byte(input logic [12:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `DRE_A_DIVMSB: r[`DRE_F_PMSB] = pmsb_q;
      `DRE_A_DIV: r = {pdiv_q, pre_q};
      `DRE_A_DIVSRC: r[`DRE_F_DEN] = den_q;
      `DRE_A_RXBG:
      begin
        r[`DRE_F_RXRST] = rxr_q;
        r[`DRE_F_BG_HI:`DRE_F_BG_LO] = bg_q;
        r[`DRE_F_BGM] = bgm_q;
      end
      `DRE_A_XTUNE:
      begin
        r[`DRE_F_TAUTO] = tauto_q;
        r[`DRE_F_TCODE_HI:`DRE_F_TCODE_LO] = tcode_q;
      end
      `DRE_A_REFOPT:
      begin
        r[`DRE_F_MULT] = mult_q;
        r[`DRE_F_XF] = xf_q;
      end
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  assign wr_data = {sh_q[6:0], sdio_s};
  assign instr_addr = {sh_q[11:0], sdio_s};
  assign instr_done = (state_q == DRE_INSTR) && rise && (cnt_q == `DRE_INSTR_LAST);

  // serial engine: 16-bit instruction (read flag first, address low 13 bits),
  // then bytes MSB first; address steps up after each byte
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rd_d = rd_q;
    addr_d = addr_q;
    tx_d = tx_q;
    wr_stb = 1'b0;
    if (csb_s)
    begin
      state_d = DRE_IDLE;
      cnt_d = 4'h0;
    end
    else
    begin
      case (state_q)
        DRE_IDLE:
        begin
          state_d = DRE_INSTR;
          cnt_d = 4'h0;
        end
        DRE_INSTR:
        begin
          if (rise)
          begin
            sh_d = {sh_q[14:0], sdio_s};
            cnt_d = cnt_q + 4'h1;
            if (instr_done)
            begin
              rd_d = sh_q[14];
              addr_d = instr_addr;
              tx_d = rd_byte(instr_addr);
              cnt_d = 4'h0;
              state_d = DRE_DATA;
            end
          end
        end
        DRE_DATA:
        begin
          if (rise)
          begin
            sh_d = {sh_q[14:0], sdio_s};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `DRE_BYTE_LAST)
            begin
              cnt_d = 4'h0;
              addr_d = addr_q + 13'h0001;
              wr_stb = ~rd_q;
              tx_d = rd_byte(addr_q + 13'h0001);
            end
          end
          else if (fall && cnt_q != 4'h0)
          begin
            // first bit already stands after the byte boundary
            tx_d = {tx_q[6:0], 1'b0};
          end
        end
        default: state_d = DRE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q <= DRE_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 16'h0000;
      rd_q <= 1'b0;
      addr_q <= 13'h0000;
      tx_q <= 8'h00;
      sclk_p_q <= 1'b0;
      strap_q <= 6'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      tx_q <= tx_d;
      sclk_p_q <= sclk_s;
      strap_q <= strap_s;
    end
  end

  assign sdio_o = tx_q[7];
  assign sdio_oe = (state_q == DRE_DATA) && rd_q && !csb_s;
  assign div_strap_code = strap_q;

  // register writes; unlisted bits and the spare register are dropped
  always_comb
  begin
    pmsb_d = pmsb_q;
    pdiv_d = pdiv_q;
    pre_d = pre_q;
    den_d = den_q;
    rxr_d = 1'b0;
    bg_d = bg_q;
    bgm_d = bgm_q;
    tauto_d = tauto_q;
    tcode_d = tcode_q;
    mult_d = mult_q;
    xf_d = xf_q;
    if (wr_stb)
    begin
      case (addr_q)
        `DRE_A_DIVMSB: pmsb_d = wr_data[`DRE_F_PMSB];
        `DRE_A_DIV:
        begin
          pdiv_d = wr_data[`DRE_F_PDIV_HI:`DRE_F_PDIV_LO];
          pre_d = wr_data[`DRE_F_PRE_HI:`DRE_F_PRE_LO];
        end
        `DRE_A_DIVSRC: den_d = wr_data[`DRE_F_DEN];
        `DRE_A_RXBG:
        begin
          rxr_d = wr_data[`DRE_F_RXRST];
          bg_d = wr_data[`DRE_F_BG_HI:`DRE_F_BG_LO];
          bgm_d = wr_data[`DRE_F_BGM];
        end
        `DRE_A_XTUNE:
        begin
          tauto_d = wr_data[`DRE_F_TAUTO];
          tcode_d = wr_data[`DRE_F_TCODE_HI:`DRE_F_TCODE_LO];
        end
        `DRE_A_REFOPT:
        begin
          mult_d = wr_data[`DRE_F_MULT];
          xf_d = wr_data[`DRE_F_XF];
        end
        default: pmsb_d = pmsb_q;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pmsb_q <= rst_post[5];
      pdiv_q <= rst_post[4:0];
      pre_q <= `DRE_RST_PRE;
      den_q <= `DRE_RST_DEN;
      rxr_q <= 1'b0;
      bg_q <= `DRE_RST_BG;
      bgm_q <= `DRE_RST_BGM;
      tauto_q <= `DRE_RST_TAUTO;
      tcode_q <= `DRE_RST_TCODE;
      mult_q <= `DRE_RST_MULT;
      xf_q <= `DRE_RST_XF;
    end
    else
    begin
      pmsb_q <= pmsb_d;
      pdiv_q <= pdiv_d;
      pre_q <= pre_d;
      den_q <= den_d;
      rxr_q <= rxr_d;
      bg_q <= bg_d;
      bgm_q <= bgm_d;
      tauto_q <= tauto_d;
      tcode_q <= tcode_d;
      mult_q <= mult_d;
      xf_q <= xf_d;
    end
  end

  assign rx_reset = rxr_q;
  // a zero post divider from the host is not trapped here
  assign cfg.post_div = {pmsb_q, pdiv_q};
  assign cfg.div_en = den_q;
  assign cfg.pre_code = pre_q;
  assign cfg.bg_manual = bgm_q;
  assign cfg.bg_adj = bg_q;
  assign cfg.tune_auto = tauto_q;
  assign cfg.tune_code = tcode_q;
  assign cfg.mult_sel = mult_q;
  assign cfg.crystal_input_force = xf_q;

  dre_sel u_sel (
    .clk(clk),
    .rstn(rstn),
    .cfg(cfg),
    .ext_ref_present(ext_s),
    .post_divider_valid(post_divider_valid),
    .post_divider(post_divider),
    .prescale_ratio(prescale_ratio),
    .bandgap_manual(bandgap_manual),
    .bandgap_value(bandgap_value),
    .tune_auto(tune_auto),
    .tune_cap_qpf(tune_cap_qpf),
    .mult_insert(mult_insert),
    .ref_use_crystal(ref_use_crystal)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_byte_end;
    state_q == DRE_DATA && rise && cnt_q == `DRE_BYTE_LAST;
  endsequence
  sequence s_byte_write;
    s_byte_end ##0 !rd_q;
  endsequence

  a_post_default: assert property ($rose(rstn) |-> cfg.post_div == 6'h20 &&
    pre_q == 3'h0)
    else $error("post divider reset value is not 32");
  a_div_write: assert property (s_byte_write ##0 addr_q == `DRE_A_DIV |=>
    {pdiv_q, pre_q} == $past(wr_data))
    else $error("divider register write lost");
  a_msb_write: assert property (s_byte_write ##0 addr_q == `DRE_A_DIVMSB |=>
    pmsb_q == $past(sdio_s))
    else $error("post divider msb write lost");
  a_rx_autoclear: assert property (rxr_q |=> !rxr_q || $past(wr_stb))
    else $error("receiver reset bit did not clear");
  a_rx_pulse: assert property (s_byte_write ##0 addr_q == `DRE_A_RXBG && sh_q[6] |=>
    rx_reset ##1 !rx_reset || $past(wr_stb))
    else $error("receiver reset pulse missing");
  a_spare_zero: assert property (instr_done && sh_q[14] &&
    instr_addr == `DRE_A_XSPARE |=> tx_q == 8'h00 ##1 sdio_oe)
    else $error("spare register read not zero");
  a_unused_read_zero: assert property (sdio_oe &&
    (addr_q == `DRE_A_XSPARE || addr_q > `DRE_A_REFOPT) |-> !sdio_o)
    else $error("unused register read not zero");
endmodule
`default_nettype wire

// file: verif/dre_host.sv
// dre_host: behavioural host driving the three-wire serial control port
`timescale 1ns/1ps
`default_nettype none
module dre_host (
  input wire logic clk,
  output logic sclk,
  output logic csb_n,
  output logic sdio_line,
  input wire logic sdio_o,
  input wire logic sdio_oe
);
  logic drv_q;
  logic dat_q;
  initial
  begin
    sclk = 1'b0;
    csb_n = 1'b1;
    drv_q = 1'b0;
    dat_q = 1'b0;
  end
  // no pull on the line: a released wire shows the inverse so stale data never looks valid
  assign sdio_line = sdio_oe ? sdio_o : (drv_q ? dat_q : ~dat_q);
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one sclk period of 8 clk: set while low, sampled at the rise
  task automatic bit_io(input logic b, input logic drive, input logic keep, output logic got);
    drv_q <= drive;
    dat_q <= b;
    wait_clk(4);
    got = sdio_line;
    sclk <= 1'b1;
    wait_clk(1);
    // release early before a read so the device can take the line
    if (!keep)
      drv_q <= 1'b0;
    wait_clk(3);
    sclk <= 1'b0;
  endtask
  // frame of n bytes; byte k of wd sits at wd[31-8k -: 8], reads shift into rdat
  task automatic xfer(input logic rd, input logic [12:0] addr, input int n,
    input logic [31:0] wd, output logic [31:0] rdat);
    logic [15:0] ins;
    logic g;
    ins = {rd, 2'b00, addr};
    rdat = 32'h0;
    csb_n <= 1'b0;
    wait_clk(4);
    for (int i = 15; i >= 0; i--)
      bit_io(ins[i], 1'b1, !(rd && i == 0), g);
    for (int i = 0; i < 8 * n; i++)
    begin
      bit_io(wd[31 - i], !rd, !rd, g);
      rdat = {rdat[30:0], g};
    end
    drv_q <= 1'b0;
    csb_n <= 1'b1;
    wait_clk(8);
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// tb_top: serial-port register tests for the divider, receiver and crystal bank
`timescale 1ns/1ps
`default_nettype none
`include "dre_regs.svh"
module tb_top;
  logic clk;
  logic rstn;
  logic sclk, csb_n, sdio_line, sdio_o, sdio_oe, ext_ref_present;
  logic [5:0] strap_y, div_strap_code, post_divider, tune_cap_qpf;
  logic post_divider_valid, rx_reset, bandgap_manual, tune_auto, mult_insert;
  logic ref_use_crystal;
  logic [3:0] prescale_ratio;
  logic [4:0] bandgap_value;
  logic [31:0] rd;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int rx_pulses = 0;
  int p;
  dre_top dre_top_inst (.clk(clk), .rstn(rstn), .sclk(sclk), .csb_n(csb_n),
    .sdio_i(sdio_line), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .strap_y(strap_y),
    .ext_ref_present(ext_ref_present), .div_strap_code(div_strap_code),
    .post_divider_valid(post_divider_valid), .post_divider(post_divider),
    .prescale_ratio(prescale_ratio), .rx_reset(rx_reset), .bandgap_manual(bandgap_manual),
    .bandgap_value(bandgap_value), .tune_auto(tune_auto), .tune_cap_qpf(tune_cap_qpf),
    .mult_insert(mult_insert), .ref_use_crystal(ref_use_crystal));
  dre_host dre_host_inst (.clk(clk), .sclk(sclk), .csb_n(csb_n), .sdio_line(sdio_line),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // whole run is about 8600 cycles; ceiling leaves wide margin
  always @(posedge clk)
  begin
    cyc++;
    if (rx_reset === 1'b1)
      rx_pulses++;
    if (cyc == 20000)
    begin
      n_fail++;
      $display("wrong value at %0t: run did not finish", $time);
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    if (got !== exp)
      n_fail++;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    dre_host_inst.xfer(1'b0, a, 1, {d, 24'h0}, rd);
  endtask
  task automatic rdchk(input logic [12:0] a, input logic [7:0] exp);
    dre_host_inst.xfer(1'b1, a, 1, 32'h0, rd);
    chk(rd[7:0], exp, "register read");
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  initial
  begin
    rstn = 1'b0;
    strap_y = 6'h2a;
    ext_ref_present = 1'b1;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    settle();
    rdchk(`DRE_A_DIVMSB, 8'h01);
    rdchk(`DRE_A_DIV, 8'h00);
    rdchk(`DRE_A_DIVSRC, 8'h00);
    rdchk(`DRE_A_RXBG, 8'h00);
    rdchk(`DRE_A_XTUNE, 8'h80);
    rdchk(`DRE_A_XSPARE, 8'h00);
    rdchk(`DRE_A_REFOPT, 8'h00);
    chk(post_divider_valid, 8'h00, "source after reset");
    chk(div_strap_code, 8'h2a, "strap code");
    chk(tune_auto, 8'h01, "tune auto");
    chk(tune_cap_qpf, 8'h00, "tune cap");
    chk(bandgap_manual, 8'h00, "bandgap mode");
    chk(ref_use_crystal, 8'h00, "ref select");
    $display("test reset values done");
    // register dividers are shadowed until the source bit is set
    wr(`DRE_A_DIV, 8'h85);
    chk(post_divider, 8'h00, "post div straps");
    chk(prescale_ratio, 8'h00, "prescale straps");
    rdchk(`DRE_A_DIV, 8'h85);
    strap_y <= 6'h15;
    settle();
    chk(div_strap_code, 8'h15, "strap code");
    wr(`DRE_A_DIVSRC, 8'hff);
    rdchk(`DRE_A_DIVSRC, 8'h80);
    chk(post_divider_valid, 8'h01, "source regs");
    chk(post_divider, 8'h30, "post div");
    chk(prescale_ratio, 8'h09, "prescale");
    $display("test divider source done");
    for (int c = 0; c < 8; c++)
    begin
      dre_host_inst.xfer(1'b0, `DRE_A_DIVMSB, 2, {8'h00, 5'h01, 3'(c), 16'h0}, rd);
      chk(post_divider, 8'h01, "post div min");
      chk(prescale_ratio, 8'(c + 4), "prescale code");
    end
    dre_host_inst.xfer(1'b0, `DRE_A_DIVMSB, 2, 32'hffff0000, rd);
    chk(post_divider, 8'h3f, "post div max");
    chk(prescale_ratio, 8'h0b, "prescale max");
    dre_host_inst.xfer(1'b1, `DRE_A_DIVMSB, 2, 32'h0, rd);
    chk(rd[15:8], 8'h01, "msb register");
    chk(rd[7:0], 8'hff, "divider register");
    wr(`DRE_A_DIVSRC, 8'h00);
    chk(post_divider_valid, 8'h00, "source straps");
    chk(prescale_ratio, 8'h00, "prescale straps");
    $display("test divider codes done");
    p = rx_pulses;
    wr(`DRE_A_RXBG, 8'hff);
    chk(8'(rx_pulses - p), 8'h01, "receiver reset pulses");
    rdchk(`DRE_A_RXBG, 8'h7d);
    chk(bandgap_manual, 8'h01, "bandgap manual");
    chk(bandgap_value, 8'h1f, "bandgap value");
    wr(`DRE_A_RXBG, 8'h54);
    chk(bandgap_manual, 8'h00, "bandgap auto");
    chk(bandgap_value, 8'h00, "bandgap auto value");
    rdchk(`DRE_A_RXBG, 8'h54);
    $display("test receiver done");
    wr(`DRE_A_XTUNE, 8'h00);
    chk(tune_auto, 8'h00, "tune manual");
    chk(tune_cap_qpf, 8'h3f, "tune cap max");
    wr(`DRE_A_XTUNE, 8'h7e);
    chk(tune_cap_qpf, 8'h01, "tune cap step");
    rdchk(`DRE_A_XTUNE, 8'h3e);
    wr(`DRE_A_XTUNE, 8'h80);
    chk(tune_auto, 8'h01, "tune auto");
    chk(tune_cap_qpf, 8'h00, "tune cap auto");
    $display("test crystal tuning done");
    wr(`DRE_A_REFOPT, 8'hff);
    rdchk(`DRE_A_REFOPT, 8'h05);
    chk(mult_insert, 8'h01, "multiplier");
    chk(ref_use_crystal, 8'h01, "crystal forced");
    ext_ref_present <= 1'b0;
    settle();
    chk(ref_use_crystal, 8'h01, "crystal forced");
    wr(`DRE_A_REFOPT, 8'h00);
    chk(mult_insert, 8'h00, "multiplier bypass");
    chk(ref_use_crystal, 8'h01, "no external ref");
    ext_ref_present <= 1'b1;
    settle();
    chk(ref_use_crystal, 8'h00, "external ref");
    $display("test reference done");
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    settle();
    rdchk(`DRE_A_DIVMSB, 8'h01);
    rdchk(`DRE_A_DIV, 8'h00);
    $display("test second reset done");
    wr(`DRE_A_XSPARE, 8'hff);
    rdchk(`DRE_A_XSPARE, 8'h00);
    wr(13'h0040, 8'hff);
    rdchk(13'h0040, 8'h00);
    $display("test unused space done");
    end_sim();
  end
endmodule
`default_nettype wire
